// ==== hdl/hriu_pkg.sv ====
package hriu_pkg;

   // Register offsets in the primary bank (five-bit address).
   localparam logic [4:0] ADDR_PART_CODE = 5'h00;
   localparam logic [4:0] ADDR_ANALOG_LB = 5'h01;
   localparam logic [4:0] ADDR_REMOTE_LB = 5'h02;
   localparam logic [4:0] ADDR_ALL_ONES = 5'h03;
   localparam logic [4:0] ADDR_LOSS_STAT = 5'h04;
   localparam logic [4:0] ADDR_FAULT_STAT = 5'h05;
   localparam logic [4:0] ADDR_LOSS_MASK = 5'h06;
   localparam logic [4:0] ADDR_FAULT_MASK = 5'h07;
   localparam logic [4:0] ADDR_LOSS_FLAGS = 5'h08;
   localparam logic [4:0] ADDR_FAULT_FLAGS = 5'h09;
   localparam logic [4:0] ADDR_SOFT_RESET = 5'h0A;
   localparam logic [4:0] ADDR_MON_SELECT = 5'h0B;
   localparam logic [4:0] ADDR_DIGITAL_LB = 5'h0C;
   localparam logic [4:0] ADDR_CRITERIA = 5'h0D;
   localparam logic [4:0] ADDR_AUTO_ONES = 5'h0E;
   localparam logic [4:0] ADDR_GLOBAL = 5'h0F;
   localparam logic [4:0] ADDR_OUT_ENABLE = 5'h12;
   localparam logic [4:0] ADDR_ALARM_STAT = 5'h13;
   localparam logic [4:0] ADDR_ALARM_MASK = 5'h14;
   localparam logic [4:0] ADDR_ALARM_FLAGS = 5'h15;
   localparam logic [4:0] ADDR_BANK = 5'h1F;

   // Reserved primary addresses and the expanded test range.
   localparam logic [4:0] ADDR_RSV_A = 5'h10;
   localparam logic [4:0] ADDR_RSV_B = 5'h11;
   localparam logic [4:0] ADDR_RSV_LO = 5'h16;
   localparam logic [4:0] ADDR_RSV_HI = 5'h1E;
   localparam logic [4:0] ADDR_EXP_TEST_LO = 5'h08;

   // Bank pointer value that opens the expanded bank, and reset values.
   localparam logic [7:0] BANK_EXPANDED = 8'hAA;
   localparam logic [7:0] REG_RESET = 8'h00;

   // Monitor select field inside the monitor configuration register.
   localparam int MON_SEL_LSB = 0;
   localparam int MON_SEL_W = 4;

   // Serial frame bit positions, counted from the first rising edge.
   localparam logic [3:0] BIT_RW = 4'h0;
   localparam logic [3:0] BIT_ADDR_LAST = 4'h5;
   localparam logic [3:0] BIT_CMD_LAST = 4'h7;
   localparam logic [3:0] BIT_DATA_FIRST = 4'h8;
   localparam logic [3:0] BIT_FRAME_LAST = 4'hF;

   // Timing: software reset lasts about one microsecond.
   localparam int CLK_PERIOD_PS = 5000;
   localparam int SOFT_RST_NS = 1000;
   localparam int SOFT_RST_CYC = (SOFT_RST_NS * 1000) / CLK_PERIOD_PS;
   localparam int RST_CNT_W = 8;

   // Phase of the serial frame on the link clock.
   typedef enum logic [2:0] {
      PH_CMD = 3'b001,
      PH_SKIP = 3'b010,
      PH_DATA = 3'b100
   } hriu_phase_t;

endpackage : hriu_pkg

// ==== hdl/hriu_top.sv ====
// Behaviour
// - A serial access is one 16-bit frame: command byte, then data byte.
// - Command byte holds read/write and five address bits; top two ignored.
// - Read shifts register contents out; write stores the data byte.
// - Interrupts come only from loss, driver-fault and alarm status changes.
// - Loss status follows the receive monitor continuously.
// - Driver-fault status follows the output driver monitor continuously.
// - Alarm status follows the alarm detector on the receive signal.
// - One latched active-low open-drain interrupt output reports every source.
// - With mask set, any status change sets the flag and pulls interrupt low.
// - With mask clear, the default, status changes are ignored.
// - Reading a status register clears its matching interrupt flags.
// - Status bits clear themselves when the condition goes away.
// - Interrupt output releases only when no flag remains set anywhere.
// - Channel 0 monitors one channel, chosen by register or select pins.
// - Monitored signal goes through channel 0 recovery and loss detection.
// - Remote loopback on channel 0 while monitoring retransmits that signal.
// - Every port addresses registers with five bits.
// - Bank pointer AAH opens the expanded bank; cleared gives primary bank.
// - Reserved primary and expanded test addresses are left at zero.
// - Writing the reset register resets all registers for about 1 us.
`timescale 1ns/1ps
`default_nettype none
module hriu_top #(
   parameter logic [7:0] PART_CODE = 8'h5A  // Arbitrary identification value.
) (
   // Core clock and reset
   input wire logic i_clock,
   input wire logic i_rst,
   // Serial host link
   input wire logic i_sclk,
   input wire logic i_scs_n,
   input wire logic i_serial_in_pin,
   output logic o_serial_out_pin,
   output logic o_serial_out_oe,
   // Line monitor status, one bit per channel
   input wire logic [7:0] i_signal_loss,
   input wire logic [7:0] i_driver_fault,
   input wire logic [7:0] i_alarm_signal,
   // Monitor selection straps
   input wire logic i_host_mode,
   input wire logic [hriu_pkg::MON_SEL_W-1:0] i_monitor_select_pins,
   // Interrupt pin, open drain
   output logic o_irq_n_out,
   output logic o_irq_n_oe,
   // Controls to the line datapath
   output logic [hriu_pkg::MON_SEL_W-1:0] o_monitor_select,
   output logic o_monitor_retransmit,
   output logic [7:0] o_remote_loopback,
   output logic o_soft_reset_busy
);
   import hriu_pkg::*;

   typedef struct packed {
      logic rst_s1;
      logic rst_s2;
      logic [3:0] cnt;
      hriu_phase_t phase;
      logic rw;
      logic [4:0] addr;
      logic [7:0] wdata;
      logic req_tgl;
      logic ack_s1;
      logic ack_s2;
      logic ack_base;
      logic [7:0] dout;
      logic serial_out_pin;
      logic sdo_oe;
   } hriu_link_t;

   typedef struct packed {
      logic req_s1;
      logic req_s2;
      logic req_seen;
      logic ack_tgl;
      logic [7:0] rdata;
      logic [7:0] los_s1;
      logic [7:0] los_s2;
      logic [7:0] los_prev;
      logic [7:0] fault_s1;
      logic [7:0] fault_s2;
      logic [7:0] fault_prev;
      logic [7:0] ais_s1;
      logic [7:0] ais_s2;
      logic [7:0] ais_prev;
      logic [7:0] los_flag;
      logic [7:0] fault_flag;
      logic [7:0] ais_flag;
      logic [7:0] los_mask;
      logic [7:0] fault_mask;
      logic [7:0] ais_mask;
      logic [7:0] analog_lb;
      logic [7:0] remote_lb;
      logic [7:0] all_ones;
      logic [7:0] mon_cfg;
      logic [7:0] digital_lb;
      logic [7:0] criteria;
      logic [7:0] auto_ones;
      logic [7:0] global_cfg;
      logic [7:0] oe;
      logic [7:0] bank;
      logic [7:0][7:0] exp_reg;
      logic [RST_CNT_W-1:0] rst_cnt;
      logic host_s1;
      logic host_s2;
      logic [MON_SEL_W-1:0] mc_s1;
      logic [MON_SEL_W-1:0] mc_s2;
      logic [MON_SEL_W-1:0] mon_sel;
      logic mon_rtx;
      logic irq_oe;
      logic busy;
   } hriu_core_t;

   hriu_link_t l;
   hriu_link_t next_l;
   hriu_core_t c;
   hriu_core_t next_c;
   logic [7:0] los_hit;
   logic [7:0] fault_hit;
   logic [7:0] ais_hit;
   logic req_new;
   logic in_exp;

   function automatic logic is_reserved(input logic exp_bank,
                                        input logic [4:0] a);
      if (exp_bank) begin
         return (a >= ADDR_EXP_TEST_LO) && (a != ADDR_BANK);
      end
      return (a == ADDR_RSV_A) || (a == ADDR_RSV_B) ||
             ((a >= ADDR_RSV_LO) && (a <= ADDR_RSV_HI));
   endfunction : is_reserved

   // Link side. The host must leave about 40 ns after the last address bit
   // so the read value can cross into this domain before the data byte.
   always_comb begin
      logic [7:0] word;
      word = 8'h00;
      next_l = l;
      next_l.rst_s1 = i_rst;
      next_l.rst_s2 = l.rst_s1;
      next_l.ack_s1 = c.ack_tgl;
      next_l.ack_s2 = l.ack_s1;
      if (l.rst_s2) begin
         next_l.cnt = 4'h0;
         next_l.phase = PH_CMD;
         next_l.req_tgl = 1'b0;
         next_l.ack_base = l.ack_s2;
         next_l.serial_out_pin = 1'b0;
         next_l.sdo_oe = 1'b0;
      end else if (i_scs_n) begin
         next_l.cnt = 4'h0;
         next_l.phase = PH_CMD;
         next_l.sdo_oe = 1'b0;
      end else begin
         next_l.cnt = l.cnt + 4'h1;
         case (l.phase)
            PH_CMD: begin
               if (l.cnt == BIT_RW) begin
                  next_l.rw = i_serial_in_pin;
               end else begin
                  next_l.addr = {i_serial_in_pin, l.addr[4:1]};
               end
               if (l.cnt == BIT_ADDR_LAST) begin
                  next_l.phase = PH_SKIP;
                  if (l.rw) begin
                     next_l.req_tgl = ~l.req_tgl;
                     next_l.ack_base = l.ack_s2;
                  end
               end
            end
            PH_SKIP: begin
               // The two upper command bits carry no meaning.
               if (l.cnt == BIT_CMD_LAST) begin
                  next_l.phase = PH_DATA;
               end
            end
            PH_DATA: begin
               next_l.wdata = {i_serial_in_pin, l.wdata[7:1]};
               if (l.rw) begin
                  if (l.cnt == BIT_DATA_FIRST) begin
                     if (l.ack_s2 != l.ack_base) begin
                        word = c.rdata;
                     end
                     next_l.serial_out_pin = word[0];
                     next_l.dout = {1'b0, word[7:1]};
                     next_l.sdo_oe = 1'b1;
                  end else begin
                     next_l.serial_out_pin = l.dout[0];
                     next_l.dout = {1'b0, l.dout[7:1]};
                  end
               end
               if (l.cnt == BIT_FRAME_LAST) begin
                  next_l.phase = PH_CMD;
                  if (!l.rw) begin
                     next_l.req_tgl = ~l.req_tgl;
                  end
               end
            end
            default: begin
               next_l.phase = PH_CMD;
            end
         endcase
      end
   end

   always_ff @(posedge i_sclk) begin
      l <= next_l;
   end

   assign in_exp = (c.bank == BANK_EXPANDED);
   assign req_new = (c.req_s2 != c.req_seen);
   assign los_hit = (c.los_s2 ^ c.los_prev) & c.los_mask;
   assign fault_hit = (c.fault_s2 ^ c.fault_prev) & c.fault_mask;
   assign ais_hit = (c.ais_s2 ^ c.ais_prev) & c.ais_mask;

   // Core side: register file, interrupt flags and monitor selection.
   always_comb begin
      logic [7:0] los_clr;
      logic [7:0] fault_clr;
      logic [7:0] ais_clr;
      logic [7:0] rd;
      los_clr = 8'h00;
      fault_clr = 8'h00;
      ais_clr = 8'h00;
      rd = 8'h00;
      next_c = c;
      next_c.req_s1 = l.req_tgl;
      next_c.req_s2 = c.req_s1;
      next_c.req_seen = c.req_s2;
      // Status bits are live copies of the monitors and clear themselves.
      next_c.los_s1 = i_signal_loss;
      next_c.los_s2 = c.los_s1;
      next_c.los_prev = c.los_s2;
      next_c.fault_s1 = i_driver_fault;
      next_c.fault_s2 = c.fault_s1;
      next_c.fault_prev = c.fault_s2;
      next_c.ais_s1 = i_alarm_signal;
      next_c.ais_s2 = c.ais_s1;
      next_c.ais_prev = c.ais_s2;
      next_c.host_s1 = i_host_mode;
      next_c.host_s2 = c.host_s1;
      next_c.mc_s1 = i_monitor_select_pins;
      next_c.mc_s2 = c.mc_s1;
      if (c.rst_cnt != '0) begin
         next_c.rst_cnt = c.rst_cnt - 1'b1;
      end
      if (req_new && l.rw) begin
         if (is_reserved(in_exp, l.addr)) begin
            rd = 8'h00;
         end else if (l.addr == ADDR_BANK) begin
            rd = c.bank;
         end else if (in_exp) begin
            rd = c.exp_reg[l.addr[2:0]];
         end else begin
            case (l.addr)
               ADDR_PART_CODE: rd = PART_CODE;
               ADDR_ANALOG_LB: rd = c.analog_lb;
               ADDR_REMOTE_LB: rd = c.remote_lb;
               ADDR_ALL_ONES: rd = c.all_ones;
               ADDR_LOSS_STAT: begin
                  rd = c.los_s2;
                  los_clr = 8'hFF;
               end
               ADDR_FAULT_STAT: begin
                  rd = c.fault_s2;
                  fault_clr = 8'hFF;
               end
               ADDR_LOSS_MASK: rd = c.los_mask;
               ADDR_FAULT_MASK: rd = c.fault_mask;
               ADDR_LOSS_FLAGS: rd = c.los_flag;
               ADDR_FAULT_FLAGS: rd = c.fault_flag;
               ADDR_MON_SELECT: rd = c.mon_cfg;
               ADDR_DIGITAL_LB: rd = c.digital_lb;
               ADDR_CRITERIA: rd = c.criteria;
               ADDR_AUTO_ONES: rd = c.auto_ones;
               ADDR_GLOBAL: rd = c.global_cfg;
               ADDR_OUT_ENABLE: rd = c.oe;
               ADDR_ALARM_STAT: begin
                  rd = c.ais_s2;
                  ais_clr = 8'hFF;
               end
               ADDR_ALARM_MASK: rd = c.ais_mask;
               ADDR_ALARM_FLAGS: rd = c.ais_flag;
               default: rd = 8'h00;
            endcase
         end
         next_c.rdata = rd;
         next_c.ack_tgl = ~c.ack_tgl;
      end else if (req_new && !is_reserved(in_exp, l.addr)) begin
         if (l.addr == ADDR_BANK) begin
            next_c.bank = l.wdata;
         end else if (in_exp) begin
            next_c.exp_reg[l.addr[2:0]] = l.wdata;
         end else begin
            case (l.addr)
               ADDR_ANALOG_LB: next_c.analog_lb = l.wdata;
               ADDR_REMOTE_LB: next_c.remote_lb = l.wdata;
               ADDR_ALL_ONES: next_c.all_ones = l.wdata;
               ADDR_LOSS_MASK: next_c.los_mask = l.wdata;
               ADDR_FAULT_MASK: next_c.fault_mask = l.wdata;
               ADDR_SOFT_RESET: next_c.rst_cnt = RST_CNT_W'(SOFT_RST_CYC);
               ADDR_MON_SELECT: next_c.mon_cfg = l.wdata;
               ADDR_DIGITAL_LB: next_c.digital_lb = l.wdata;
               ADDR_CRITERIA: next_c.criteria = l.wdata;
               ADDR_AUTO_ONES: next_c.auto_ones = l.wdata;
               ADDR_GLOBAL: next_c.global_cfg = l.wdata;
               ADDR_OUT_ENABLE: next_c.oe = l.wdata;
               ADDR_ALARM_MASK: next_c.ais_mask = l.wdata;
               default: next_c.remote_lb = c.remote_lb;
            endcase
         end
      end
      // A change landing on the clearing read still sets its flag.
      next_c.los_flag = (c.los_flag & ~los_clr) | los_hit;
      next_c.fault_flag = (c.fault_flag & ~fault_clr) | fault_hit;
      next_c.ais_flag = (c.ais_flag & ~ais_clr) | ais_hit;
      next_c.irq_oe = |{c.los_flag, c.fault_flag, c.ais_flag};
      if (c.host_s2) begin
         next_c.mon_sel = c.mon_cfg[MON_SEL_LSB +: MON_SEL_W];
      end else begin
         next_c.mon_sel = c.mc_s2;
      end
      // Channel 0 recovery and loss detection see the selected line.
      next_c.mon_rtx = (c.mon_sel != '0) && c.remote_lb[0];
      if (c.rst_cnt != '0) begin
         next_c.los_flag = REG_RESET;
         next_c.fault_flag = REG_RESET;
         next_c.ais_flag = REG_RESET;
         next_c.los_mask = REG_RESET;
         next_c.fault_mask = REG_RESET;
         next_c.ais_mask = REG_RESET;
         next_c.analog_lb = REG_RESET;
         next_c.remote_lb = REG_RESET;
         next_c.all_ones = REG_RESET;
         next_c.mon_cfg = REG_RESET;
         next_c.digital_lb = REG_RESET;
         next_c.criteria = REG_RESET;
         next_c.auto_ones = REG_RESET;
         next_c.global_cfg = REG_RESET;
         next_c.oe = REG_RESET;
         next_c.bank = REG_RESET;
         next_c.exp_reg = '0;
      end
      // Busy is registered so the pin comes straight from a flip-flop.
      next_c.busy = (next_c.rst_cnt != '0);
      if (i_rst) begin
         next_c = '0;
         next_c.req_s1 = l.req_tgl;
         next_c.req_s2 = c.req_s1;
         next_c.req_seen = c.req_s2;
      end
   end

   always_ff @(posedge i_clock) begin
      c <= next_c;
   end

   assign o_serial_out_pin = l.serial_out_pin;
   assign o_serial_out_oe = l.sdo_oe;
   assign o_irq_n_out = 1'b0;  // Open drain: only ever pulls low.
   assign o_irq_n_oe = c.irq_oe;
   assign o_monitor_select = c.mon_sel;
   assign o_monitor_retransmit = c.mon_rtx;
   assign o_remote_loopback = c.remote_lb;
   assign o_soft_reset_busy = c.busy;

   a_mask_edge_sets: assert property (
      @(posedge i_clock) disable iff (i_rst)
      (|los_hit) && (c.rst_cnt == '0)
      |=> ((c.los_flag & $past(los_hit)) == $past(los_hit)))
      else $error("Masked loss change did not set its flag.");
   a_mask_off_ignored: assert property (
      @(posedge i_clock) disable iff (i_rst)
      (c.ais_mask == 8'h00) && (c.ais_flag == 8'h00) |=> c.ais_flag == 8'h00)
      else $error("Alarm flag set while its mask was clear.");
   a_read_clears: assert property (
      @(posedge i_clock) disable iff (i_rst)
      req_new && l.rw && !in_exp && (l.addr == ADDR_FAULT_STAT) &&
      (fault_hit == 8'h00) |=> c.fault_flag == 8'h00)
      else $error("Fault flags not cleared by status read.");
   a_irq_asserts: assert property (
      @(posedge i_clock) disable iff (i_rst)
      (|{c.los_flag, c.fault_flag, c.ais_flag}) |=> o_irq_n_oe)
      else $error("Pending flag but interrupt pin released.");
   a_irq_releases: assert property (
      @(posedge i_clock) disable iff (i_rst)
      !(|{c.los_flag, c.fault_flag, c.ais_flag}) |=> !o_irq_n_oe)
      else $error("Interrupt pin held with no flag pending.");
   a_status_live: assert property (
      @(posedge i_clock) disable iff (i_rst)
      req_new && l.rw && !in_exp && (l.addr == ADDR_LOSS_STAT)
      |=> c.rdata == $past(c.los_s2))
      else $error("Loss status read did not return live value.");
   a_reserved_zero: assert property (
      @(posedge i_clock) disable iff (i_rst)
      req_new && l.rw && is_reserved(in_exp, l.addr) |=> c.rdata == 8'h00)
      else $error("Reserved address read non-zero.");
   a_bank_switch: assert property (
      @(posedge i_clock) disable iff (i_rst)
      req_new && !l.rw && (l.addr == ADDR_BANK) &&
      (l.wdata == BANK_EXPANDED) && (c.rst_cnt == '0)
      |=> in_exp)
      else $error("Bank pointer write did not open expanded bank.");
   a_soft_reset_len: assert property (
      @(posedge i_clock) disable iff (i_rst)
      req_new && !l.rw && !in_exp && (l.addr == ADDR_SOFT_RESET)
      |=> (c.rst_cnt == SOFT_RST_CYC) ##1 (c.rst_cnt == SOFT_RST_CYC - 1))
      else $error("Software reset count wrong.");
   a_mon_host: assert property (
      @(posedge i_clock) disable iff (i_rst)
      c.host_s2 |=> o_monitor_select == $past(c.mon_cfg[MON_SEL_W-1:0]))
      else $error("Monitor select does not follow register.");
   a_cmd_fetch: assert property (
      @(posedge i_sclk) disable iff (l.rst_s2)
      !i_scs_n && (l.phase == PH_CMD) && (l.cnt == BIT_ADDR_LAST) && l.rw
      |=> l.req_tgl != $past(l.req_tgl))
      else $error("Read command did not request a fetch.");
   a_sdo_drive: assert property (
      @(posedge i_sclk) disable iff (l.rst_s2)
      !i_scs_n && (l.phase == PH_DATA) && l.rw && (l.cnt == BIT_DATA_FIRST)
      |=> o_serial_out_oe)
      else $error("Serial output not driven for read data.");

   c_write: cover property (@(posedge i_clock) disable iff (i_rst)
      req_new && !l.rw);
   c_read: cover property (@(posedge i_clock) disable iff (i_rst)
      req_new && l.rw);
   c_irq: cover property (@(posedge i_clock) disable iff (i_rst)
      $rose(o_irq_n_oe));
   c_soft_reset: cover property (@(posedge i_clock) disable iff (i_rst)
      $rose(o_soft_reset_busy));

endmodule : hriu_top
`default_nettype wire

// ==== tb/hriu_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module hriu_host (
   // Serial link toward the device
   output logic o_sclk,
   output logic o_scs_n,
   output logic o_sdi,
   input wire logic i_sdo,
   input wire logic i_sdo_oe
);
   initial begin
      o_sclk = 1'b0;
      o_scs_n = 1'b1;
      o_sdi = 1'b0;
   end

   // Edges with select high; the data line keeps changing so a stale bit
   // can never pass for a driven one.
   task automatic idle(input int n);
      repeat (n) begin
         o_sdi = ~o_sdi;
         #6 o_sclk = 1'b1;
         #6 o_sclk = 1'b0;
      end
   endtask : idle

   task automatic xfer(input logic rd, input logic [6:0] adr,
                       input logic [7:0] wd, output logic [7:0] rdat);
      logic [15:0] f;
      f = {wd, adr, rd};
      rdat = 8'h00;
      o_scs_n = 1'b0;
      for (int k = 0; k < 16; k++) begin
         o_sdi = f[k];
         #6 o_sclk = 1'b1;
         #6 o_sclk = 1'b0;
         // An undriven output bit is taken as unknown.
         if (k >= 8) rdat[k-8] = (i_sdo_oe === 1'b1) ? i_sdo : 1'bx;
         if (rd && k == 5) #40;
      end
      o_scs_n = 1'b1;
      #40;
      idle(1);
   endtask : xfer
endmodule : hriu_host
`default_nettype wire

// ==== tb/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
   import hriu_pkg::*;
   localparam logic [7:0] CODE = 8'h3C; // Arbitrary identification value.
   localparam logic [4:0] RW [12] = '{5'h01, 5'h02, 5'h03, 5'h06, 5'h07,
      5'h0B, 5'h0C, 5'h0D, 5'h0E, 5'h0F, 5'h12, 5'h14};
   localparam logic [4:0] RO [5] = '{5'h00, 5'h10, 5'h11, 5'h16, 5'h1E};
   localparam logic [4:0] STA [3] = '{5'h04, 5'h05, 5'h13};
   localparam logic [4:0] MSK [3] = '{5'h06, 5'h07, 5'h14};
   localparam logic [4:0] FLG [3] = '{5'h08, 5'h09, 5'h15};
   logic i_clock, i_rst, sclk, scs_n, serial_in_pin, serial_out_pin, sdo_oe, irq_out, irq_oe;
   logic host_mode, busy, retx;
   logic [7:0] st [3];
   logic [7:0] remote_lb;
   logic [7:0] shadow [32];
   logic [3:0] pins, mon_sel;
   int n_mismatch = 0;
   int checked = 0;
   // The interrupt line has a pull-up.
   wire irq_line = irq_oe ? irq_out : 1'b1;

   hriu_top #(.PART_CODE(CODE)) uut (.i_clock(i_clock), .i_rst(i_rst),
      .i_sclk(sclk), .i_scs_n(scs_n), .i_serial_in_pin(serial_in_pin),
      .o_serial_out_pin(serial_out_pin), .o_serial_out_oe(sdo_oe),
      .i_signal_loss(st[0]), .i_driver_fault(st[1]),
      .i_alarm_signal(st[2]), .i_host_mode(host_mode),
      .i_monitor_select_pins(pins), .o_irq_n_out(irq_out),
      .o_irq_n_oe(irq_oe), .o_monitor_select(mon_sel),
      .o_monitor_retransmit(retx), .o_remote_loopback(remote_lb),
      .o_soft_reset_busy(busy));
   hriu_host host (.o_sclk(sclk), .o_scs_n(scs_n), .o_sdi(serial_in_pin),
      .i_sdo(serial_out_pin), .i_sdo_oe(sdo_oe));

   initial begin
      i_clock = 1'b0;
      forever #2.5 i_clock = ~i_clock;
   end

   task automatic cmp(input string what, input logic [7:0] exp,
                      input logic [7:0] got);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp

   task automatic give_verdict;
      $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : give_verdict

   task automatic wait_sig(input bit on_busy, input logic v, input int n);
      for (int i = 0; i < n; i++) begin
         @(negedge i_clock);
         if ((on_busy ? busy : irq_line) === v) return;
      end
      n_mismatch++;
      $display("MISMATCH wait expected %b seen timeout", v);
      give_verdict();
   endtask : wait_sig

   // The two ignored command bits carry random values.
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      logic [7:0] junk;
      host.xfer(1'b0, {2'($urandom), a}, d, junk);
      @(negedge i_clock);
   endtask : wr

   task automatic rdr(input logic [4:0] a, output logic [7:0] d);
      host.xfer(1'b1, {2'($urandom), a}, 8'($urandom), d);
      @(negedge i_clock);
   endtask : rdr

   initial begin
      logic [7:0] d;
      int ch;
      void'($urandom(32'hF1352242));
      i_rst = 1'b1;
      host_mode = 1'b1;
      pins = 4'h0;
      foreach (st[s]) st[s] = 8'h00;
      repeat (4) @(negedge i_clock);
      host.idle(4);
      @(negedge i_clock);
      i_rst = 1'b0;
      host.idle(3);
      for (int i = 0; i < 32; i++) begin
         if (i != 10) begin
            rdr(5'(i), d);
            cmp("reset value", (i == 0) ? CODE : 8'h00, d);
         end
      end
      foreach (RW[j]) begin
         shadow[RW[j]] = 8'($urandom);
         wr(RW[j], shadow[RW[j]]);
      end
      foreach (RW[j]) begin
         rdr(RW[j], d);
         cmp("readback", shadow[RW[j]], d);
      end
      foreach (RO[j]) begin
         wr(RO[j], 8'hFF);
         rdr(RO[j], d);
         cmp("read-only", (RO[j] == 5'h00) ? CODE : 8'h00, d);
      end
      wr(5'h0B, 8'h05);
      wr(5'h02, 8'h01);
      repeat (8) @(negedge i_clock);
      cmp("monitor select", 8'h05, {4'h0, mon_sel});
      cmp("retransmit", 8'h01, {7'h00, retx});
      cmp("remote loopback", 8'h01, remote_lb);
      pins = 4'($urandom % 15 + 1);
      host_mode = 1'b0;
      repeat (8) @(negedge i_clock);
      cmp("pin select", {4'h0, pins}, {4'h0, mon_sel});
      for (int s = 0; s < 3; s++) begin
         ch = $urandom % 8;
         wr(MSK[s], 8'h00);
         st[s][ch] = ~st[s][ch];
         repeat (20) @(negedge i_clock);
         cmp("masked pin", 8'h01, {7'h00, irq_line});
         rdr(FLG[s], d);
         cmp("masked flags", 8'h00, d);
         wr(MSK[s], 8'h01 << ch);
         st[s][ch] = ~st[s][ch];
         wait_sig(1'b0, 1'b0, 20);
         cmp("pin low", 8'h00, {7'h00, irq_line});
         rdr(FLG[s], d);
         cmp("flags", 8'h01 << ch, d);
         rdr(STA[s], d);
         cmp("status", st[s], d);
         wait_sig(1'b0, 1'b1, 20);
         rdr(FLG[s], d);
         cmp("cleared flags", 8'h00, d);
      end
      wr(5'h06, 8'hFF);
      wr(5'h07, 8'hFF);
      st[0][1] = ~st[0][1];
      st[1][6] = ~st[1][6];
      wait_sig(1'b0, 1'b0, 20);
      rdr(5'h04, d);
      cmp("loss status", st[0], d);
      repeat (20) @(negedge i_clock);
      cmp("pin still low", 8'h00, {7'h00, irq_line});
      rdr(5'h05, d);
      cmp("fault status", st[1], d);
      wait_sig(1'b0, 1'b1, 20);
      cmp("pin released", 8'h01, {7'h00, irq_line});
      wr(5'h1F, BANK_EXPANDED);
      wr(5'h03, 8'hC3);
      rdr(5'h03, d);
      cmp("expanded store", 8'hC3, d);
      rdr(5'h0C, d);
      cmp("test register", 8'h00, d);
      wr(5'h1F, 8'h00);
      rdr(5'h03, d);
      cmp("primary bank", shadow[3], d);
      wr(5'h0A, 8'($urandom));
      cmp("reset busy", 8'h01, {7'h00, busy});
      wait_sig(1'b1, 1'b0, 300);
      cmp("loopback after reset", 8'h00, remote_lb);
      cmp("retransmit after reset", 8'h00, {7'h00, retx});
      rdr(5'h06, d);
      cmp("mask after reset", 8'h00, d);
      give_verdict();
   end
endmodule : tb
`default_nettype wire
